// ### vfcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vfcr_host_model (
  // Clock
  input wire logic ref_clk,
  // Host strobe bus
  output logic [15:0] host_addr,
  output logic host_wr_en,
  output logic host_rd_en,
  output logic [8:0] host_wr_data,
  input wire logic [8:0] host_rd_data,
  input wire logic host_rd_valid
);
  initial begin
    host_addr = 16'h0000;
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_wr_data = 9'h000;
  end

  // Released lines show the inverse of their last value, not a stale copy
  task automatic write_reg(input logic [15:0] addr, input logic [8:0] data);
    @(negedge ref_clk);
    host_addr = addr;
    host_wr_data = data;
    host_wr_en = 1'b1;
    @(negedge ref_clk);
    host_wr_en = 1'b0;
    host_addr = ~addr;
    host_wr_data = ~data;
  endtask : write_reg

  // Strobe is one cycle wide; the answer is taken one cycle after the strobe
  task automatic read_reg(input logic [15:0] addr, output logic [8:0] data,
                          output logic valid);
    @(negedge ref_clk);
    host_addr = addr;
    host_rd_en = 1'b1;
    @(negedge ref_clk);
    data = host_rd_data;
    valid = host_rd_valid;
    host_rd_en = 1'b0;
    host_addr = ~addr;
  endtask : read_reg
endmodule : vfcr_host_model
`default_nettype wire

// ### vfcr_ovf_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfcr_regs.svh"

module vfcr_ovf_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Event and snapshot
  input wire logic event_pulse,
  input wire logic snap_strobe,
  // Held count
  output vfcr_pkg::vfcr_count_type held_count
);
  import vfcr_pkg::*;

  vfcr_count_type count_reg;
  vfcr_count_type held_reg;

  // An event on the snapshot cycle starts the next count at one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `VFCR_RST_COUNT;
    end else if (snap_strobe) begin
      count_reg <= {15'h0000, event_pulse};
    end else if (event_pulse && count_reg != `VFCR_CNT_MAX) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      held_reg <= `VFCR_RST_COUNT;
    end else if (snap_strobe) begin
      held_reg <= count_reg;
    end
  end

  assign held_count = held_reg;

  count_saturates_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (count_reg == `VFCR_CNT_MAX && !snap_strobe) |=> count_reg == `VFCR_CNT_MAX)
    else $error("overflow counter wrapped past its maximum");

endmodule : vfcr_ovf_counter
`default_nettype wire

// ### vfcr_pkg.sv
package vfcr_pkg;

  typedef enum logic [1:0] {
    VFCR_PICK_LUMA = 2'h0,
    VFCR_PICK_U = 2'h1,
    VFCR_PICK_V = 2'h2,
    VFCR_PICK_V_ALT = 2'h3
  } vfcr_pick_type;

  typedef enum logic [1:0] {
    VFCR_CORR_INTERNAL = 2'h0,
    VFCR_CORR_EXTERNAL = 2'h1,
    VFCR_CORR_HOLD = 2'h2,
    VFCR_CORR_HOLD_ALT = 2'h3
  } vfcr_corr_mode_type;

  typedef logic [15:0] vfcr_count_type;

endpackage : vfcr_pkg

// ### vfcr_regs.svh
`ifndef VFCR_REGS_SVH
`define VFCR_REGS_SVH

// Host addresses; reads and writes at one address reach different registers
`define VFCR_OFS_300 16'h0300
`define VFCR_OFS_301 16'h0301
`define VFCR_OFS_302 16'h0302
`define VFCR_OFS_303 16'h0303
`define VFCR_OFS_304 16'h0304
`define VFCR_OFS_305 16'h0305
`define VFCR_OFS_306 16'h0306
`define VFCR_OFS_307 16'h0307

// Reset values
`define VFCR_RST_WINDOW 8'h00
`define VFCR_RST_GAIN 9'h000
`define VFCR_RST_PICK 2'h0
`define VFCR_RST_CTRL1 8'h00
`define VFCR_RST_CTRL2 7'h00
`define VFCR_RST_CORR 3'h0
`define VFCR_RST_YDLY 3'h7
`define VFCR_RST_COUNT 16'h0000

// Field positions of chroma_offset_ctrl
`define VFCR_U_FIX_MSB 2
`define VFCR_U_FIX_LSB 0
`define VFCR_V_FIX_MSB 5
`define VFCR_V_FIX_LSB 3
`define VFCR_MODE_MSB 7
`define VFCR_MODE_LSB 6

// Field positions of clamp_loop_ctrl
`define VFCR_TAU_MSB 1
`define VFCR_TAU_LSB 0
`define VFCR_YDLY_MSB 3
`define VFCR_YDLY_LSB 2
`define VFCR_EXTRA_MSB 6
`define VFCR_EXTRA_LSB 4

// Chroma clamp loop time constant in lines
`define VFCR_TAU_LINES_0 6'h04
`define VFCR_TAU_LINES_1 6'h09
`define VFCR_TAU_LINES_2 6'h13
`define VFCR_TAU_LINES_3 6'h27

// Luma delay offset subtracted from the code
`define VFCR_YDLY_BIAS 3'h1

// Saturation value of the overflow counters
`define VFCR_CNT_MAX 16'hffff

`endif

// ### vfcr_regs_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfcr_regs.svh"

// Notes on behaviour
// R1: three 9-bit gain settings, luma, U, V
// R2: pick code 0 luma, 1 U, 2/3 V
// R3: level-11 count read as high, low bytes
// R4: level-10 count read at next two addresses
// R5: level-01 count read at 304/305
// R6: U fix value applied in external mode
// R7: V fix value applied in external mode
// R8: mode field: internal, external, hold, hold
// R9: time constant 4, 9, 19, 39 lines
// R10: luma shifted -1, 0, 1, 2 samples
// R11: measured U/V offsets readable at 306/307
// R12: reads and writes share addresses, distinct registers
module vfcr_regs_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host interface
  input wire logic [15:0] host_addr,
  input wire logic host_wr_en,
  input wire logic host_rd_en,
  input wire logic [8:0] host_wr_data,
  output logic [8:0] host_rd_data,
  output logic host_rd_valid,
  // Converter level events, bit 0 luma, 1 U, 2 V
  input wire logic [2:0] lvl3_event,
  input wire logic [2:0] lvl2_event,
  input wire logic [2:0] lvl1_event,
  input wire logic stats_snapshot,
  // Measured clamp offsets, gain 16
  input wire logic [6:0] measured_u_offset,
  input wire logic [6:0] measured_v_offset,
  // Clamp window and gains
  output logic [7:0] clamp_window_begin,
  output logic [7:0] clamp_window_end,
  output logic [8:0] luma_gain_setting,
  output logic [8:0] u_gain_setting,
  output logic [8:0] v_gain_setting,
  output vfcr_pkg::vfcr_pick_type converter_pick,
  // Chroma offset correction
  output vfcr_pkg::vfcr_corr_mode_type chroma_offset_fix_mode,
  output logic [2:0] u_offset_applied,
  output logic [2:0] v_offset_applied,
  // Clamp loop and luma delay
  output logic [5:0] chroma_clamp_time_const,
  output logic [2:0] luma_delay_shift,
  output logic [2:0] clamp_loop_extra
);
  import vfcr_pkg::*;

  logic [7:0] clamp_begin_reg;
  logic [7:0] clamp_end_reg;
  logic [8:0] luma_gain_reg;
  logic [8:0] u_gain_reg;
  logic [8:0] v_gain_reg;
  logic [1:0] pick_reg;
  logic [7:0] chroma_offset_ctrl_reg;
  logic [6:0] clamp_loop_ctrl_reg;
  logic [2:0] u_applied_reg;
  logic [2:0] v_applied_reg;
  logic [5:0] time_const_reg;
  logic [2:0] ydly_shift_reg;
  logic [8:0] rd_data_reg;
  logic [8:0] rd_data_next;
  logic rd_valid_reg;
  logic [8:0] event_vec;
  vfcr_count_type held_count [9];
  logic [1:0] conv_index;
  logic [2:0] u_fix_value;
  logic [2:0] v_fix_value;
  logic [1:0] fix_mode;
  logic [1:0] tau_code;
  logic [1:0] ydly_code;
  vfcr_count_type lvl3_sel;
  vfcr_count_type lvl2_sel;
  vfcr_count_type lvl1_sel;

  // Host writes: only control registers are reachable here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clamp_begin_reg <= `VFCR_RST_WINDOW;
      clamp_end_reg <= `VFCR_RST_WINDOW;
    end else if (host_wr_en) begin
      if (host_addr == `VFCR_OFS_300) begin
        clamp_begin_reg <= host_wr_data[7:0]; // [R12]
      end
      if (host_addr == `VFCR_OFS_301) begin
        clamp_end_reg <= host_wr_data[7:0]; // [R12]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      luma_gain_reg <= `VFCR_RST_GAIN;
      u_gain_reg <= `VFCR_RST_GAIN;
      v_gain_reg <= `VFCR_RST_GAIN;
    end else if (host_wr_en) begin
      if (host_addr == `VFCR_OFS_302) begin
        luma_gain_reg <= host_wr_data; // [R1]
      end
      if (host_addr == `VFCR_OFS_303) begin
        u_gain_reg <= host_wr_data; // [R1]
      end
      if (host_addr == `VFCR_OFS_304) begin
        v_gain_reg <= host_wr_data; // [R1]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pick_reg <= `VFCR_RST_PICK;
    end else if (host_wr_en && host_addr == `VFCR_OFS_305) begin
      pick_reg <= host_wr_data[1:0]; // [R2]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chroma_offset_ctrl_reg <= `VFCR_RST_CTRL1;
      clamp_loop_ctrl_reg <= `VFCR_RST_CTRL2;
    end else if (host_wr_en) begin
      if (host_addr == `VFCR_OFS_306) begin
        chroma_offset_ctrl_reg <= host_wr_data[7:0]; // [R8]
      end
      if (host_addr == `VFCR_OFS_307) begin
        clamp_loop_ctrl_reg <= host_wr_data[6:0]; // [R9]
      end
    end
  end

  assign u_fix_value = chroma_offset_ctrl_reg[`VFCR_U_FIX_MSB:`VFCR_U_FIX_LSB];
  assign v_fix_value = chroma_offset_ctrl_reg[`VFCR_V_FIX_MSB:`VFCR_V_FIX_LSB];
  assign fix_mode = chroma_offset_ctrl_reg[`VFCR_MODE_MSB:`VFCR_MODE_LSB];
  assign tau_code = clamp_loop_ctrl_reg[`VFCR_TAU_MSB:`VFCR_TAU_LSB];
  assign ydly_code = clamp_loop_ctrl_reg[`VFCR_YDLY_MSB:`VFCR_YDLY_LSB];

  // Applied chroma correction; internal mode removes the gain of 16
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      u_applied_reg <= `VFCR_RST_CORR;
      v_applied_reg <= `VFCR_RST_CORR;
    end else begin
      case (fix_mode)
        VFCR_CORR_INTERNAL: begin
          u_applied_reg <= measured_u_offset[6:4];
          v_applied_reg <= measured_v_offset[6:4];
        end
        VFCR_CORR_EXTERNAL: begin
          u_applied_reg <= u_fix_value; // [R6]
          v_applied_reg <= v_fix_value; // [R7]
        end
        default: begin
          u_applied_reg <= u_applied_reg; // [R8]
          v_applied_reg <= v_applied_reg; // [R8]
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      time_const_reg <= `VFCR_TAU_LINES_0;
    end else begin
      case (tau_code)
        2'h0: time_const_reg <= `VFCR_TAU_LINES_0; // [R9]
        2'h1: time_const_reg <= `VFCR_TAU_LINES_1; // [R9]
        2'h2: time_const_reg <= `VFCR_TAU_LINES_2; // [R9]
        default: time_const_reg <= `VFCR_TAU_LINES_3; // [R9]
      endcase
    end
  end

  // Luma delay code 0..3 gives a shift of -1..2 in two's complement
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ydly_shift_reg <= `VFCR_RST_YDLY;
    end else begin
      ydly_shift_reg <= {1'b0, ydly_code} - `VFCR_YDLY_BIAS; // [R10]
    end
  end

  // Overflow statistics: index is three times (3 minus level) plus converter
  assign event_vec = {lvl1_event, lvl2_event, lvl3_event};

  for (genvar i = 0; i < 9; i++) begin : g_ovf
    vfcr_ovf_counter u_counter (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .event_pulse(event_vec[i]),
      .snap_strobe(stats_snapshot),
      .held_count(held_count[i])
    );
  end

  // Codes 2 and 3 both pick the V converter
  assign conv_index = pick_reg[1] ? 2'h2 : {1'b0, pick_reg[0]}; // [R2]
  assign lvl3_sel = held_count[conv_index];
  assign lvl2_sel = held_count[4'(conv_index) + 4'h3];
  assign lvl1_sel = held_count[4'(conv_index) + 4'h6];

  // Host reads: only status registers are visible here
  always_comb begin
    rd_data_next = 9'h000;
    case (host_addr)
      `VFCR_OFS_300: rd_data_next = {1'b0, lvl3_sel[15:8]}; // [R3] [R12]
      `VFCR_OFS_301: rd_data_next = {1'b0, lvl3_sel[7:0]}; // [R3]
      `VFCR_OFS_302: rd_data_next = {1'b0, lvl2_sel[15:8]}; // [R4]
      `VFCR_OFS_303: rd_data_next = {1'b0, lvl2_sel[7:0]}; // [R4]
      `VFCR_OFS_304: rd_data_next = {1'b0, lvl1_sel[15:8]}; // [R5]
      `VFCR_OFS_305: rd_data_next = {1'b0, lvl1_sel[7:0]}; // [R5]
      `VFCR_OFS_306: rd_data_next = {2'h0, measured_u_offset}; // [R11]
      `VFCR_OFS_307: rd_data_next = {2'h0, measured_v_offset}; // [R11]
      default: rd_data_next = 9'h000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= 9'h000;
    end else if (host_rd_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= host_rd_en;
    end
  end

  assign host_rd_data = rd_data_reg;
  assign host_rd_valid = rd_valid_reg;
  assign clamp_window_begin = clamp_begin_reg;
  assign clamp_window_end = clamp_end_reg;
  assign luma_gain_setting = luma_gain_reg;
  assign u_gain_setting = u_gain_reg;
  assign v_gain_setting = v_gain_reg;
  assign converter_pick = vfcr_pick_type'(pick_reg);
  assign chroma_offset_fix_mode = vfcr_corr_mode_type'(fix_mode);
  assign u_offset_applied = u_applied_reg;
  assign v_offset_applied = v_applied_reg;
  assign chroma_clamp_time_const = time_const_reg;
  assign luma_delay_shift = ydly_shift_reg; // [R10]
  assign clamp_loop_extra = clamp_loop_ctrl_reg[`VFCR_EXTRA_MSB:`VFCR_EXTRA_LSB];

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence read_at(logic [15:0] a);
    host_rd_en && host_addr == a;
  endsequence

  sequence write_at(logic [15:0] a);
    host_wr_en && !host_rd_en && host_addr == a;
  endsequence

  luma_gain_load_a: assert property ( // [R1]
    write_at(`VFCR_OFS_302) |=> luma_gain_setting == $past(host_wr_data))
    else $error("luma gain not loaded from host write");

  v_gain_load_a: assert property ( // [R1]
    write_at(`VFCR_OFS_304) |=> v_gain_setting == $past(host_wr_data) && host_rd_valid == 1'b0)
    else $error("V gain not loaded from host write");

  pick_v_alias_a: assert property ( // [R2]
    converter_pick[1] |-> lvl1_sel == held_count[8] && lvl3_sel == held_count[2])
    else $error("pick codes 2 and 3 do not select V");

  lvl3_hi_read_a: assert property ( // [R3]
    (read_at(`VFCR_OFS_300) ##0 (!stats_snapshot && !host_wr_en))
      |=> host_rd_valid && host_rd_data == {1'b0, held_count[conv_index][15:8]})
    else $error("level-11 high byte read wrong");

  lvl2_lo_read_a: assert property ( // [R4]
    (read_at(`VFCR_OFS_303) ##0 !stats_snapshot && !host_wr_en)
      |=> host_rd_data == {1'b0, held_count[4'(conv_index) + 4'h3][7:0]})
    else $error("level-10 low byte read wrong");

  lvl1_pair_read_a: assert property ( // [R5]
    (read_at(`VFCR_OFS_304) ##[1:2] read_at(`VFCR_OFS_305))
      ##0 ($stable(pick_reg) && $stable(held_count[8]))
      |-> host_rd_data[8] == 1'b0 ##1 host_rd_valid)
    else $error("level-01 byte pair not returned");

  ext_fix_apply_a: assert property ( // [R6] [R7]
    (fix_mode == VFCR_CORR_EXTERNAL) [*2]
      |-> u_offset_applied == $past(u_fix_value) && v_offset_applied == $past(v_fix_value))
    else $error("external correction values not applied");

  hold_keeps_a: assert property ( // [R8]
    fix_mode[1] |=> $stable(u_offset_applied) && $stable(v_offset_applied))
    else $error("held correction changed");

  tau_lines_a: assert property ( // [R9]
    (tau_code == 2'h3 && $stable(tau_code)) |=> chroma_clamp_time_const == 6'h27)
    else $error("time constant code 3 not 39 lines");

  luma_delay_a: assert property ( // [R10]
    ydly_code == 2'h0 |=> luma_delay_shift == 3'h7)
    else $error("luma delay code 0 not minus one");

  offset_read_a: assert property ( // [R11]
    read_at(`VFCR_OFS_307) |=> host_rd_data == {2'h0, $past(measured_v_offset)})
    else $error("measured V offset read wrong");

  shared_addr_a: assert property ( // [R12]
    (write_at(`VFCR_OFS_300) ##1 !host_wr_en
      ##1 (read_at(`VFCR_OFS_300) ##0 (!host_wr_en && !stats_snapshot)))
      |=> host_rd_data == {1'b0, lvl3_sel[15:8]}
        && clamp_window_begin == $past(host_wr_data[7:0], 3))
    else $error("shared address write leaked into read");

  rd_valid_pulse_a: assert property ( // [R3]
    host_rd_valid == $past(host_rd_en))
    else $error("read valid is not one cycle after the strobe");

  unmapped_read_a: assert property ( // [R12]
    (host_rd_en && (host_addr < `VFCR_OFS_300 || host_addr > `VFCR_OFS_307))
      |=> host_rd_data == 9'h000)
    else $error("unmapped read returned nonzero data");

  window_load_a: assert property ( // [R12]
    write_at(`VFCR_OFS_300) |=> clamp_window_begin == $past(host_wr_data[7:0]))
    else $error("clamp window begin not loaded from host write");

  u_gain_load_a: assert property ( // [R1]
    write_at(`VFCR_OFS_303) |=> u_gain_setting == $past(host_wr_data))
    else $error("U gain not loaded from host write");

  pick_load_a: assert property ( // [R2]
    write_at(`VFCR_OFS_305) |=> converter_pick == $past(host_wr_data[1:0]))
    else $error("converter pick not loaded from host write");

  int_fix_apply_a: assert property ( // [R8]
    fix_mode == VFCR_CORR_INTERNAL
      |=> u_offset_applied == $past(measured_u_offset[6:4])
        && v_offset_applied == $past(measured_v_offset[6:4]))
    else $error("internal correction not taken from measured offsets");

endmodule : vfcr_regs_bank
`default_nettype wire

// ### video_frontend_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module video_frontend_control_regs_test;
  import vfcr_pkg::*;
  logic ref_clk, reset_n, host_wr_en, host_rd_en, host_rd_valid, stats_snapshot, rd_ok;
  logic [15:0] host_addr, exp_cnt;
  logic [8:0] host_wr_data, host_rd_data, rd_val, luma_gain_setting, u_gain_setting;
  logic [8:0] v_gain_setting;
  logic [7:0] clamp_window_begin, clamp_window_end;
  logic [2:0] lvl3_event, lvl2_event, lvl1_event, u_offset_applied, v_offset_applied;
  logic [2:0] luma_delay_shift, clamp_loop_extra;
  logic [6:0] measured_u_offset, measured_v_offset;
  logic [5:0] chroma_clamp_time_const;
  vfcr_pick_type converter_pick;
  vfcr_corr_mode_type chroma_offset_fix_mode;
  int bad_count, checks_done, cycle_count, c;
  int cnt [3][3] = '{'{2, 5, 8}, '{3, 6, 9}, '{4, 7, 300}};
  logic [5:0] tau_lines [4] = '{6'h04, 6'h09, 6'h13, 6'h27};
  logic [2:0] ydly [4] = '{3'h7, 3'h0, 3'h1, 3'h2};

  vfcr_host_model vfcr_host_model_inst (.ref_clk(ref_clk), .host_addr(host_addr),
    .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_wr_data(host_wr_data),
    .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid));

  vfcr_regs_bank vfcr_regs_bank_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_addr(host_addr), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_wr_data(host_wr_data), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
    .lvl3_event(lvl3_event), .lvl2_event(lvl2_event), .lvl1_event(lvl1_event),
    .stats_snapshot(stats_snapshot), .measured_u_offset(measured_u_offset),
    .measured_v_offset(measured_v_offset), .clamp_window_begin(clamp_window_begin),
    .clamp_window_end(clamp_window_end), .luma_gain_setting(luma_gain_setting),
    .u_gain_setting(u_gain_setting), .v_gain_setting(v_gain_setting),
    .converter_pick(converter_pick), .chroma_offset_fix_mode(chroma_offset_fix_mode),
    .u_offset_applied(u_offset_applied), .v_offset_applied(v_offset_applied),
    .chroma_clamp_time_const(chroma_clamp_time_const), .luma_delay_shift(luma_delay_shift),
    .clamp_loop_extra(clamp_loop_extra));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check_val(input string name, input logic [8:0] exp, input logic [8:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_val

  task automatic read_check(input logic [15:0] addr, input logic [8:0] exp, input string name);
    vfcr_host_model_inst.read_reg(addr, rd_val, rd_ok);
    check_val({name, " valid"}, 9'h001, {8'h00, rd_ok});
    check_val(name, exp, rd_val);
  endtask : read_check

  task automatic wr(input logic [15:0] addr, input logic [8:0] data);
    vfcr_host_model_inst.write_reg(addr, data);
  endtask : wr

  task automatic check_applied(input logic [2:0] u, input logic [2:0] v);
    repeat (2) @(negedge ref_clk);
    check_val("u_applied", {6'h00, u}, {6'h00, u_offset_applied});
    check_val("v_applied", {6'h00, v}, {6'h00, v_offset_applied});
  endtask : check_applied

  initial begin
    reset_n = 1'b0;
    {lvl3_event, lvl2_event, lvl1_event, stats_snapshot} = '0;
    measured_u_offset = 7'h35;
    measured_v_offset = 7'h4a;
    bad_count = 0;
    checks_done = 0;
    cycle_count = 0;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    check_val("tau_rst", 9'h004, {3'h0, chroma_clamp_time_const});
    check_val("ydly_rst", 9'h007, {6'h00, luma_delay_shift});
    wr(16'h0301, 9'h0c3);
    wr(16'h0302, 9'h1ff);
    wr(16'h0303, 9'h100);
    wr(16'h0304, 9'h0aa);
    wr(16'h0308, 9'h1ff);
    wr(16'h0300, 9'h05a);
    check_val("win_begin", 9'h05a, {1'b0, clamp_window_begin});
    check_val("win_end", 9'h0c3, {1'b0, clamp_window_end});
    check_val("y_gain", 9'h1ff, luma_gain_setting);
    check_val("u_gain", 9'h100, u_gain_setting);
    check_val("v_gain", 9'h0aa, v_gain_setting);
    read_check(16'h0300, 9'h000, "rd_300");
    read_check(16'h0308, 9'h000, "rd_308");
    for (int i = 0; i < 4; i++) begin
      wr(16'h0307, {2'h0, 3'h5, i[1:0], i[1:0]});
      @(negedge ref_clk);
      check_val("tau", {3'h0, tau_lines[i]}, {3'h0, chroma_clamp_time_const});
      check_val("ydly", {6'h00, ydly[i]}, {6'h00, luma_delay_shift});
      check_val("extra", 9'h005, {6'h00, clamp_loop_extra});
    end
    wr(16'h0306, 9'h06b);
    check_applied(3'h3, 3'h5);
    check_val("mode", 9'h001, {7'h00, chroma_offset_fix_mode});
    wr(16'h0306, 9'h000);
    check_applied(3'h3, 3'h4);
    wr(16'h0306, 9'h080);
    measured_u_offset = 7'h7f;
    measured_v_offset = 7'h25;
    check_applied(3'h3, 3'h4);
    wr(16'h0306, 9'h0c0);
    check_applied(3'h3, 3'h4);
    check_val("mode", 9'h003, {7'h00, chroma_offset_fix_mode});
    read_check(16'h0306, 9'h07f, "rd_u_err");
    read_check(16'h0307, 9'h025, "rd_v_err");
    for (int k = 0; k < 300; k++) begin
      @(negedge ref_clk);
      for (int j = 0; j < 3; j++) begin
        lvl3_event[j] = (k < cnt[0][j]);
        lvl2_event[j] = (k < cnt[1][j]);
        lvl1_event[j] = (k < cnt[2][j]);
      end
    end
    @(negedge ref_clk);
    {lvl3_event, lvl2_event, lvl1_event} = '0;
    stats_snapshot = 1'b1;
    @(negedge ref_clk);
    stats_snapshot = 1'b0;
    for (int p = 0; p < 4; p++) begin
      wr(16'h0305, {7'h00, p[1:0]});
      check_val("pick", {7'h00, p[1:0]}, {7'h00, converter_pick});
      c = (p == 3) ? 2 : p;
      for (int l = 0; l < 3; l++) begin
        exp_cnt = cnt[l][c][15:0];
        read_check(16'h0300 + 16'(2 * l), {1'b0, exp_cnt[15:8]}, "cnt_hi");
        read_check(16'h0301 + 16'(2 * l), {1'b0, exp_cnt[7:0]}, "cnt_lo");
      end
    end
    report_and_stop();
  end
endmodule : video_frontend_control_regs_test
`default_nettype wire
